// ---- verilog/caf_filter_ctrl.sv ----
// Acceptance filtering and message queue control behind a Wishbone slave.
// Assumes a classic Wishbone master and a protocol engine on clk_i.
//
// Functional notes
// - Standard mask bit one compares identifier bit.
// - Extended mask bit one compares extended bit.
// - Type bit forces frame type to match filter.
// - Masks writable only in configuration mode.
// - Per-filter enable bit activates that filter.
// - Two-bit field picks one of four masks.
// - Five-bit field routes to queue 0-15; rest reserved.
// - Filter fields writable only while filter disabled.
// - Four filters per control word, one byte each.
// - Queue depth equals size field plus one, at most sixteen.
// - Queue reset bit clears itself when done.
// - Transmit increment advances head by one.
// - Receive increment advances tail by one.
// - Receive payload-only mode drops identifier; transmit ignores.
// - Size and payload-only change only in configuration.
// - Aborted flag updates on completion or reset.
// - Arbitration and error flags clear on read.
// - Direction bit selects transmit or receive queue.
// - Aliases at 0x4/0x8/0xC clear, set, invert.
`timescale 1ns/10ps
`include "caf_defines.svh"
module caf_filter_ctrl import caf_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        msg_valid_i,
  input  wire caf_id_t     msg_id_i,
  input  wire caf_txev_t   tx_ev_i,
  output caf_accept_t      accept_o,
  output logic      [2:0]  operating_mode_state_o,
  output logic      [15:0] send_request_o
);
  logic [31:0] ctrl_ff;
  logic [31:0] mask_ff [4];
  logic [31:0] flt_ff  [4];
  logic [31:0] fid_ff  [16];
  logic [31:0] fcon_ff [16];
  logic [31:0] nxt_fcon [16];
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        ack_ff;
  caf_accept_t acc_ff;
  caf_accept_t nxt_acc;
  logic [3:0]  head [16];
  logic [3:0]  tail [16];

  logic        req;
  logic        wr;
  logic        rd;
  logic [7:0]  widx;
  logic [1:0]  op;
  logic [31:0] bmask;
  logic        cfg_mode;

  // Decode of the current Wishbone request; ack_ff blocks a double take.
  assign req      = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr       = req & wb_we_i;
  assign rd       = req & ~wb_we_i;
  assign widx     = wb_adr_i[11:4];
  assign op       = wb_adr_i[3:2];
  assign bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cfg_mode = ctrl_ff[`CAF_OPM_MSB:`CAF_OPM_LSB] == `CAF_OPM_CFG;

  // Applies a plain, clear, set or invert write to the writable bits only.
  function automatic logic [31:0] alias_wr(input logic [31:0] old, input logic [31:0] d,
                                           input logic [31:0] wm);
    logic [31:0] b;
    logic [31:0] r;
    b = d & bmask & wm;
    case (op)
      `CAF_OP_WRITE: r = (old & ~(bmask & wm)) | b;
      `CAF_OP_CLR:   r = old & ~b;
      `CAF_OP_SET:   r = old | b;
      default:       r = old ^ b;
    endcase
    return r;
  endfunction : alias_wr

  // Writable bits of a filter control word: enables always, the rest
  // only in bytes whose filter is currently off.
  function automatic logic [31:0] flt_wm(input logic [31:0] old);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[8*b+7]       = 1'b1;
      m[8*b +: 7]    = {7{~old[8*b+7]}};
    end
    return m;
  endfunction : flt_wm

  // Bus handshake: ack one cycle after the request, dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff  <= req;
      rdat_ff <= rd ? nxt_rdat : 32'h0000_0000;
    end
  end

  // Read mux; aliases read back the base register, holes read as zero.
  always_comb begin
    nxt_rdat = 32'h0000_0000;
    if (widx == `CAF_IDX_CTRL) begin
      nxt_rdat = ctrl_ff;
    end else if (widx[7:2] == 6'(`CAF_IDX_MASK >> 2)) begin
      nxt_rdat = mask_ff[widx[1:0]];
    end else if (widx[7:2] == 6'(`CAF_IDX_FLT >> 2)) begin
      nxt_rdat = flt_ff[widx[1:0]];
    end else if (widx[7:4] == 4'(`CAF_IDX_FID >> 4)) begin
      nxt_rdat = fid_ff[widx[3:0]];
    end else if (widx[7:4] == 4'(`CAF_IDX_FCON >> 4)) begin
      nxt_rdat = fcon_ff[widx[3:0]];
    end else if (widx[7:4] == 4'(`CAF_IDX_FPTR >> 4)) begin
      nxt_rdat = {20'h0_0000, tail[widx[3:0]], 4'h0, head[widx[3:0]]};
    end
  end

  // Controller control word; only the operating mode field is held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CAF_CTRL_RST;
    end else if (wr && widx == `CAF_IDX_CTRL) begin
      ctrl_ff <= alias_wr(ctrl_ff, wb_dat_i, `CAF_CTRL_WM);
    end
  end

  // Acceptance masks. Writes outside configuration mode are dropped so a
  // running filter never sees a half-updated mask.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i) begin
        mask_ff[i] <= 32'h0000_0000;
      end else if (wr && cfg_mode && widx == 8'(`CAF_IDX_MASK + i)) begin
        mask_ff[i] <= alias_wr(mask_ff[i], wb_dat_i, `CAF_ID_WM);
      end
    end
  end

  // Filter control words, four filters each, one byte per filter.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i) begin
        flt_ff[i] <= 32'h0000_0000;
      end else if (wr && widx == 8'(`CAF_IDX_FLT + i)) begin
        flt_ff[i] <= alias_wr(flt_ff[i], wb_dat_i, flt_wm(flt_ff[i]));
      end
    end
  end

  // Filter identifiers, same layout as the masks; the type bit holds the frame type.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) begin
      if (rst_i) begin
        fid_ff[i] <= 32'h0000_0000;
      end else if (wr && widx == 8'(`CAF_IDX_FID + i)) begin
        fid_ff[i] <= alias_wr(fid_ff[i], wb_dat_i, `CAF_ID_WM);
      end
    end
  end

  // Queue control words. Reset and increment pulse for one cycle, then
  // clear; a send result arriving with a read clear still sets its flag.
  always_comb begin
    logic [31:0] n;
    n = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      n = fcon_ff[i];
      n[`CAF_FC_RST] = 1'b0;
      n[`CAF_FC_INC] = 1'b0;
      if (fcon_ff[i][`CAF_FC_RST]) begin
        n[`CAF_FC_ABAT] = 1'b0;
        n[`CAF_FC_LARB] = 1'b0;
        n[`CAF_FC_ERR]  = 1'b0;
      end
      if (wr && widx == 8'(`CAF_IDX_FCON + i)) begin
        n = alias_wr(n, wb_dat_i, cfg_mode ? `CAF_FC_WM_CFG : `CAF_FC_WM_RUN);
      end
      if (rd && widx == 8'(`CAF_IDX_FCON + i)) begin
        n[`CAF_FC_LARB] = 1'b0;
        n[`CAF_FC_ERR]  = 1'b0;
      end
      if (tx_ev_i.valid && tx_ev_i.queue == 4'(i)) begin
        n[`CAF_FC_ABAT] = tx_ev_i.aborted;
        n[`CAF_FC_LARB] = n[`CAF_FC_LARB] | tx_ev_i.arb_lost;
        n[`CAF_FC_ERR]  = n[`CAF_FC_ERR] | tx_ev_i.error;
      end
      nxt_fcon[i] = n;
    end
  end

  // Queue control registers.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) begin
      if (rst_i) begin
        fcon_ff[i] <= 32'h0000_0000;
      end else begin
        fcon_ff[i] <= nxt_fcon[i];
      end
    end
  end

  // Pointer unit per queue. Direction decides which side software moves:
  // a send queue's head, a receive queue's tail.
  for (genvar q = 0; q < 16; q++) begin : g_queue
    logic txq;
    logic inc;
    logic push;
    logic pop;
    logic [3:0] last;
    assign txq  = fcon_ff[q][`CAF_FC_QUEUE_DIRECTION_TX];
    assign inc  = fcon_ff[q][`CAF_FC_INC];
    assign last = fcon_ff[q][`CAF_FC_SIZE_MSB] ? 4'hF :
                  fcon_ff[q][`CAF_FC_SIZE_LSB +: 4];
    assign push = txq ? inc : (acc_ff.valid && acc_ff.queue == 4'(q));
    assign pop  = txq ? (tx_ev_i.valid && tx_ev_i.queue == 4'(q) && !tx_ev_i.aborted)
                      : inc;
    caf_queue_ptr #(.PTR_W(4)) u_ptr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (fcon_ff[q][`CAF_FC_RST]),
      .last_i  (last),
      .push_i  (push),
      .pop_i   (pop),
      .head_o  (head[q]),
      .tail_o  (tail[q])
    );
  end

  // Filter search; the lowest-numbered matching filter wins.
  always_comb begin
    logic [7:0]  fb;
    logic [31:0] m;
    logic [31:0] fid;
    logic        hit;
    fb      = 8'h00;
    m       = 32'h0000_0000;
    fid     = 32'h0000_0000;
    hit     = 1'b0;
    nxt_acc = '0;
    for (int f = 0; f < 16; f++) begin
      fb  = flt_ff[f / 4][8*(f % 4) +: 8];
      m   = mask_ff[fb[6:5]];
      fid = fid_ff[f];
      hit = fb[7];
      hit = hit && (((msg_id_i.std_id_mask_bits ^ fid[31:21]) & m[31:21]) == 11'h000);
      hit = hit && (!msg_id_i.ext ||
                    (((msg_id_i.ext_id_mask_bits ^ fid[17:0]) & m[17:0]) == 18'h0_0000));
      hit = hit && (!m[`CAF_ID_TYPE] || (msg_id_i.ext == fid[`CAF_ID_TYPE]));
      hit = hit && !fb[4] && !fcon_ff[fb[3:0]][`CAF_FC_QUEUE_DIRECTION_TX];
      if (msg_valid_i && hit && !nxt_acc.valid) begin
        nxt_acc.valid        = 1'b1;
        nxt_acc.queue        = fb[3:0];
        nxt_acc.filter       = 4'(f);
        nxt_acc.payload_only = fcon_ff[fb[3:0]][`CAF_FC_PAYLOAD_ONLY_STORE];
      end
    end
  end

  // Registered acceptance result, a one-cycle pulse per accepted frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Outputs come straight from flip-flops.
  assign wb_ack_o               = ack_ff;
  assign wb_dat_o               = rdat_ff;
  assign accept_o               = acc_ff;
  assign operating_mode_state_o = ctrl_ff[`CAF_OPM_MSB:`CAF_OPM_LSB];
  for (genvar q = 0; q < 16; q++) begin : g_req
    assign send_request_o[q] = fcon_ff[q][`CAF_FC_SEND_REQUEST];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_mask_lock: assert property (!cfg_mode |=> $stable(mask_ff[0]))
    else $error("mask changed outside configuration mode");
  a_size_lock: assert property (!cfg_mode
    |=> $stable({fcon_ff[3][20:16], fcon_ff[3][12]}))
    else $error("queue size changed outside configuration mode");
  a_filter_lock: assert property (flt_ff[2][23] |=> $stable(flt_ff[2][22:16]))
    else $error("enabled filter reconfigured");
  a_reset_clears: assert property (fcon_ff[5][14] |=> !fcon_ff[5][14]
    && (fcon_ff[5][6:4] == 3'h0 || $past(tx_ev_i.valid)))
    else $error("queue reset bit or flags not cleared");
  a_inc_pulse: assert property (fcon_ff[5][13] |=> !fcon_ff[5][13])
    else $error("increment bit did not self-clear");
  a_read_clear: assert property (rd && widx == 8'(`CAF_IDX_FCON + 5) && !tx_ev_i.valid
    |=> fcon_ff[5][5:4] == 2'h0)
    else $error("read did not clear send flags");
  a_alias_set: assert property (wr && widx == 8'(`CAF_IDX_FLT + 2) && op == `CAF_OP_SET
    && wb_sel_i == 4'hF |=> (flt_ff[2] & $past(wb_dat_i) & 32'h8080_8080)
    == ($past(wb_dat_i) & 32'h8080_8080))
    else $error("set alias lost enable bits");
  a_accept_cause: assert property (accept_o.valid |-> $past(msg_valid_i))
    else $error("acceptance without a frame");
  a_rx_only: assert property (accept_o.valid
    |-> !fcon_ff[accept_o.queue][`CAF_FC_QUEUE_DIRECTION_TX] || $changed(fcon_ff[accept_o.queue]))
    else $error("frame routed to a send queue");
  // Handshake timing and filter refusals; the queue checks watch the queues the bench drives.
  a_ack_follows: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data shown without acknowledge");
  a_filter_off: assert property (msg_valid_i && !flt_ff[2][23]
    |=> !(accept_o.valid && accept_o.filter == 4'hA))
    else $error("disabled filter accepted a frame");
  a_reserved_queue: assert property (msg_valid_i && flt_ff[2][31] && flt_ff[2][28]
    |=> !(accept_o.valid && accept_o.filter == 4'hB))
    else $error("filter with a reserved queue code accepted a frame");
  a_rx_tail_step: assert property (fcon_ff[3][13] && !fcon_ff[3][7] && !fcon_ff[3][14]
    && tail[3] != g_queue[3].last |=> tail[3] == 4'($past(tail[3]) + 1'b1))
    else $error("receive increment did not advance the tail by one");

  // Main scenarios; the bench reaches all but c_qreset, as it never resets queue 0.
  c_accept: cover property (accept_o.valid && accept_o.payload_only);
  c_qreset: cover property (fcon_ff[0][14] ##1 !fcon_ff[0][14]);
  c_abort:  cover property (tx_ev_i.valid && tx_ev_i.aborted);
  c_send_ok: cover property (tx_ev_i.valid && !tx_ev_i.aborted && !tx_ev_i.arb_lost);
  c_locked_mask: cover property (wr && !cfg_mode && widx == `CAF_IDX_MASK);
endmodule : caf_filter_ctrl

// ---- verilog/caf_defines.svh ----
// Offsets, field positions and reset values of the acceptance filter block.
// Assumes a 12-bit Wishbone byte address; each register owns a 16-byte slot.
`ifndef CAF_DEFINES_SVH
`define CAF_DEFINES_SVH
// Slot indices (byte address bits 11:4).
`define CAF_IDX_CTRL    8'h00
`define CAF_IDX_MASK    8'h04
`define CAF_IDX_FLT     8'h08
`define CAF_IDX_FID     8'h10
`define CAF_IDX_FCON    8'h20
`define CAF_IDX_FPTR    8'h30
// Alias operations (byte address bits 3:2).
`define CAF_OP_WRITE    2'h0
`define CAF_OP_CLR      2'h1
`define CAF_OP_SET      2'h2
// Controller control word.
`define CAF_OPM_MSB     23
`define CAF_OPM_LSB     21
`define CAF_OPM_CFG     3'h4
`define CAF_CTRL_RST    32'h0080_0000
`define CAF_CTRL_WM     32'h00E0_0000
// Mask and filter identifier layout.
`define CAF_ID_WM       32'hFFEB_FFFF
`define CAF_ID_TYPE     19
// Queue control word fields.
`define CAF_FC_SIZE_MSB 20
`define CAF_FC_SIZE_LSB 16
`define CAF_FC_RST      14
`define CAF_FC_INC      13
`define CAF_FC_PAYLOAD_ONLY_STORE    12
`define CAF_FC_QUEUE_DIRECTION_TX     7
`define CAF_FC_ABAT     6
`define CAF_FC_LARB     5
`define CAF_FC_ERR      4
`define CAF_FC_SEND_REQUEST    3
`define CAF_FC_WM_RUN   32'h0000_608F
`define CAF_FC_WM_CFG   32'h001F_708F
`endif

// ---- verilog/caf_pkg.sv ----
// Types shared by the acceptance filter and queue control block.
// Assumes the protocol engine delivers identifiers and send results on clk_i.
package caf_pkg;
  // Identifier of a received frame.
  typedef struct packed {
    logic [10:0] std_id_mask_bits;
    logic        ext;
    logic [17:0] ext_id_mask_bits;
  } caf_id_t;
  // Result of one send attempt from the protocol engine.
  typedef struct packed {
    logic       valid;
    logic [3:0] queue;
    logic       aborted;
    logic       arb_lost;
    logic       error;
  } caf_txev_t;
  // Acceptance decision for one received frame.
  typedef struct packed {
    logic       valid;
    logic [3:0] queue;
    logic [3:0] filter;
    logic       payload_only;
  } caf_accept_t;
endpackage : caf_pkg

// ---- verilog/caf_queue_ptr.sv ----
// Head and tail pointers of one message queue, wrapping at its depth.
// Assumes push, pop and clear are single-cycle pulses on clk_i.
`timescale 1ns/10ps
module caf_queue_ptr #(
  parameter int PTR_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic [PTR_W-1:0] last_i,
  input  wire logic             push_i,
  input  wire logic             pop_i,
  output logic      [PTR_W-1:0] head_o,
  output logic      [PTR_W-1:0] tail_o
);
  if (PTR_W < 1 || PTR_W > 5) begin : g_bad_width
    $error("caf_queue_ptr: PTR_W must be 1 to 5");
  end

  logic [PTR_W-1:0] head_ff;
  logic [PTR_W-1:0] tail_ff;

  // Head advances once per push and wraps after the last slot.
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      head_ff <= '0;
    end else if (push_i) begin
      head_ff <= (head_ff == last_i) ? '0 : PTR_W'(head_ff + 1'b1);
    end
  end

  // Tail advances once per pop; a clear beats any pending pop.
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      tail_ff <= '0;
    end else if (pop_i) begin
      tail_ff <= (tail_ff == last_i) ? '0 : PTR_W'(tail_ff + 1'b1);
    end
  end

  assign head_o = head_ff;
  assign tail_o = tail_ff;

  a_head_step: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i && !clear_i && head_ff != last_i |=> head_ff == PTR_W'($past(head_ff) + 1'b1))
    else $error("queue head did not advance by one");
  a_tail_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    pop_i && !clear_i && tail_ff == last_i |=> tail_ff == '0)
    else $error("queue tail did not wrap at depth");
endmodule : caf_queue_ptr

// ---- sim/caf_engine_model.sv ----
// Stand-in for the protocol engine: delivers received identifiers and send results.
// Assumes the bench calls its tasks from one process synchronous to clk_i.
`timescale 1ns/10ps
module caf_engine_model import caf_pkg::*; (
  input  wire logic clk_i,
  output logic      msg_valid_o,
  output caf_id_t   msg_id_o,
  output caf_txev_t tx_ev_o
);
  // Idle at time zero so the block never sees an unknown request.
  initial begin
    msg_valid_o = 1'b0;
    msg_id_o    = '0;
    tx_ev_o     = '0;
  end

  // One-cycle frame pulse; the identifier is inverted afterwards so a stale id never matches.
  task automatic send_frame(input logic [10:0] std_id_mask_bits, input logic ext, input logic [17:0] ext_id_mask_bits);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_id_o    <= {std_id_mask_bits, ext, ext_id_mask_bits};
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_id_o    <= ~msg_id_o;
  endtask : send_frame

  // One-cycle result of a send attempt on queue q.
  task automatic send_result(input logic [3:0] q, input logic ab, input logic al, input logic er);
    @(posedge clk_i);
    tx_ev_o <= {1'b1, q, ab, al, er};
    @(posedge clk_i);
    tx_ev_o <= '0;
  endtask : send_result
endmodule : caf_engine_model

// ---- sim/can_accept_filter_fifo_ctrl_bench.sv ----
// Self-checking bench: register accesses over classic Wishbone plus engine traffic.
// Assumes caf_filter_ctrl, caf_engine_model and the package are compiled before it.
`timescale 1ns/10ps
module can_accept_filter_fifo_ctrl_bench import caf_pkg::*; ;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic        ack;
  logic        mvalid;
  caf_id_t     mid;
  caf_txev_t   txev;
  caf_accept_t acc;
  logic [2:0]  opm;
  logic [15:0] send_request;
  int          errors;
  int          check_count;
  int          cycles;

  caf_filter_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .msg_valid_i(mvalid), .msg_id_i(mid), .tx_ev_i(txev), .accept_o(acc),
    .operating_mode_state_o(opm), .send_request_o(send_request)
  );

  caf_engine_model eng (
    .clk_i(clk_i), .msg_valid_o(mvalid), .msg_id_o(mid), .tx_ev_o(txev)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run; reached from the main sequence or the timeout.
  task automatic results();
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // Cuts a hang short; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled, then a full idle cycle.
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    // Only the bench timeout ends a wait for ack.
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    bus(a, 1'b1, d, s);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000, 4'hF);
    chk(rdat, exp);
  endtask : rd

  // Sends a frame and compares {valid, queue, filter, payload_only} one cycle later.
  task automatic frm(input logic [10:0] std_id_mask_bits, input logic ext, input logic [9:0] e);
    eng.send_frame(std_id_mask_bits, ext, 18'h3FFFF);
    #1;
    chk({22'h0, (acc.valid ? 10'(acc) : 10'h000)}, {22'h0, e});
  endtask : frm

  // Main sequence: reset, configuration, frame path, send path, run mode locks.
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h000, 32'h0080_0000);
    chk({29'h0, opm}, 32'h0000_0004);
    rd(12'h200, 32'h0000_0000);
    rd(12'h0C0, 32'h0000_0000);
    wr(12'h050, 32'hFFFF_FFFF);
    rd(12'h050, 32'hFFEB_FFFF);
    wr(12'h054, 32'h0000_FFFF);
    rd(12'h050, 32'hFFEB_0000);
    wr(12'h058, 32'h0000_00F0);
    rd(12'h050, 32'hFFEB_00F0);
    wr(12'h05C, 32'hFFEB_00F0);
    rd(12'h050, 32'h0000_0000);
    wr(12'h050, 32'hFFE0_0000);
    wr(12'h1A0, 32'h2460_0000);
    wr(12'h1B0, 32'h2460_0000);
    wr(12'h230, 32'h0004_1000);
    wr(12'h0A0, 32'h3023_0000);
    wr(12'h0A8, 32'h8000_0000);
    frm(11'h123, 1'b0, 10'h000);
    wr(12'h0A8, 32'h0080_0000);
    wr(12'h0A0, 32'h00FF_0000, 4'h4);
    rd(12'h0A0, 32'hB0A3_0000);
    frm(11'h123, 1'b0, 10'h275);
    frm(11'h122, 1'b0, 10'h000);
    frm(11'h123, 1'b1, 10'h275);
    rd(12'h330, 32'h0000_0002);
    wr(12'h238, 32'h0000_2000);
    rd(12'h330, 32'h0000_0102);
    rd(12'h230, 32'h0004_1000);
    wr(12'h058, 32'h0008_0000);
    frm(11'h123, 1'b1, 10'h000);
    frm(11'h123, 1'b0, 10'h275);
    wr(12'h250, 32'h0001_0088);
    chk({16'h0, send_request}, 32'h0000_0020);
    repeat (3) wr(12'h258, 32'h0000_2000);
    rd(12'h350, 32'h0000_0001);
    eng.send_result(4'h5, 1'b0, 1'b1, 1'b1);
    rd(12'h250, 32'h0001_00B8);
    rd(12'h250, 32'h0001_0088);
    rd(12'h350, 32'h0000_0101);
    eng.send_result(4'h5, 1'b0, 1'b0, 1'b0);
    rd(12'h350, 32'h0000_0001);
    eng.send_result(4'h5, 1'b1, 1'b0, 1'b0);
    rd(12'h250, 32'h0001_00C8);
    wr(12'h258, 32'h0000_4000);
    rd(12'h250, 32'h0001_0088);
    rd(12'h350, 32'h0000_0000);
    wr(12'h000, 32'h0000_0000);
    chk({29'h0, opm}, 32'h0000_0000);
    wr(12'h040, 32'hFFFF_FFFF);
    rd(12'h040, 32'h0000_0000);
    wr(12'h230, 32'h0000_0000);
    rd(12'h230, 32'h0004_1000);
    results();
  end
endmodule : can_accept_filter_fifo_ctrl_bench
